// ### src/exu_pkg.sv
// Constants, operation codes and state type of the execution block.
package exu_pkg;

	// ****************************************
	// Register offsets.
	// ****************************************
	localparam logic [7:0] EXU_OFS_CMD      = 8'h00;
	localparam logic [7:0] EXU_OFS_SRC_A    = 8'h04;
	localparam logic [7:0] EXU_OFS_SRC_B    = 8'h08;
	localparam logic [7:0] EXU_OFS_PC       = 8'h0C;
	localparam logic [7:0] EXU_OFS_IMM      = 8'h10;
	localparam logic [7:0] EXU_OFS_MEM_DATA = 8'h14;
	localparam logic [7:0] EXU_OFS_RESULT   = 8'h18;
	localparam logic [7:0] EXU_OFS_STATUS   = 8'h1C;
	localparam logic [7:0] EXU_OFS_NEXT_PC  = 8'h20;
	localparam logic [7:0] EXU_OFS_HI       = 8'h24;
	localparam logic [7:0] EXU_OFS_LO       = 8'h28;
	localparam logic [7:0] EXU_OFS_EXC_PC   = 8'h2C;
	localparam logic [7:0] EXU_OFS_ERR_PC   = 8'h30;
	localparam logic [7:0] EXU_OFS_DBG_PC   = 8'h34;
	localparam logic [7:0] EXU_OFS_SW       = 8'h38;
	localparam logic [7:0] EXU_OFS_LINK     = 8'h3C;
	localparam logic [7:0] EXU_OFS_MEM_ADDR = 8'h40;

	// ****************************************
	// Field positions and fixed values.
	// ****************************************
	localparam int unsigned EXU_ST_BUSY   = 0;
	localparam int unsigned EXU_ST_WR     = 1;
	localparam int unsigned EXU_ST_TAKEN  = 2;
	localparam int unsigned EXU_ST_NULL   = 3;
	localparam int unsigned EXU_ST_BRK    = 4;
	localparam int unsigned EXU_ST_DBG    = 5;
	localparam int unsigned EXU_ST_LINK   = 6;
	localparam int unsigned EXU_SW_EXL    = 1;
	localparam int unsigned EXU_SW_ERL    = 2;
	localparam logic [4:0]  EXU_LINK_REG  = 5'h1F;
	localparam logic [5:0]  EXU_DIV_STEPS = 6'h20;
	localparam logic [4:0]  EXU_CP0_SW    = 5'h01;
	localparam logic [4:0]  EXU_CP0_XPC   = 5'h02;
	localparam logic [4:0]  EXU_CP0_EEPC  = 5'h03;
	localparam logic [4:0]  EXU_CP0_DPC   = 5'h04;
	localparam logic [4:0]  EXU_CP0_LINK  = 5'h05;

	// ****************************************
	// Operation codes and state.
	// ****************************************
	typedef enum logic [5:0] {
		OP_BLE_Z, OP_BLE_ZL, OP_BNEG, OP_BNEG_L, OP_BNEG_LNK, OP_BNEG_LNKL,
		OP_BUNEQ, OP_BUNEQ_L, OP_BREAKPT, OP_CNT_ONES, OP_CNT_ZEROS,
		OP_DBG_RET, OP_DIV_S, OP_DIV_U, OP_EXC_RET, OP_JMP, OP_JMP_LNK,
		OP_RJMP_LNK, OP_RJMP, OP_LD_BS, OP_LD_BZ, OP_LD_HS, OP_LD_HZ,
		OP_LD_LNK, OP_LD_UPPER, OP_LD_WORD, OP_MACC, OP_MACC_U, OP_CP_RD,
		OP_RD_HI, OP_RD_LO, OP_MOV_NZ, OP_MOV_Z, OP_MUL_SUBTRACT_S, OP_MUL_SUBTRACT_U,
		OP_CP_WR, OP_WR_HI, OP_WR_LO, OP_MUL_REG, OP_MUL_S, OP_MUL_U
	} exu_op_t;

	typedef enum logic {EXU_IDLE, EXU_DIVIDE} exu_fsm_t;

	typedef struct packed {
		logic        wait_r;
		logic [31:0] rdata;
		exu_fsm_t    fsm;
		logic [5:0]  div_cnt;
		logic        neg_q;
		logic        neg_r;
		logic [31:0] den;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] pc;
		logic [31:0] imm;
		logic [31:0] mem_data;
		logic [31:0] result;
		logic [4:0]  dest;
		logic        dest_wr;
		logic        taken;
		logic        nullify;
		logic        brk;
		logic        dbg;
		logic        llflag;
		logic [31:0] next_pc;
		logic [31:0] hi;
		logic [31:0] lo;
		logic [31:0] xpc;
		logic [31:0] eepc;
		logic [31:0] dpc;
		logic [31:0] sw;
		logic [31:0] link_addr;
		logic [31:0] mem_addr;
	} exu_state_t;

	localparam exu_state_t EXU_STATE_RST = '{wait_r: 1'b1, fsm: EXU_IDLE,
		default: '0};

endpackage : exu_pkg

// ### src/exu_core.sv
// Execution datapath for branches, jumps, loads, multiply and divide.
`timescale 1ns/1ps
module exu_core (
	// Clock, reset and enable.
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	// Avalon-MM register slave.
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest
);

	// ****************************************
	// Helper functions.
	// ****************************************

	// Merges write data into a register under the byte enables.
	function automatic logic [31:0] merge(logic [31:0] old,
		logic [31:0] wd, logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Sign-extends a 16-bit immediate.
	function automatic logic [31:0] sext16(logic [31:0] v);
		return {{16{v[15]}}, v[15:0]};
	endfunction : sext16

	// Counts equal bits from the top end.
	function automatic logic [5:0] lead_count(logic [31:0] v, logic b);
		logic [5:0] n;
		logic       run;
		n = 6'h00;
		run = 1'b1;
		for (int i = 31; i >= 0; i--) begin
			if (run && v[i] == b) begin
				n = n + 6'h01;
			end else begin
				run = 1'b0;
			end
		end
		return n;
	endfunction : lead_count

	// Magnitude of a value, signed or not.
	function automatic logic [31:0] mag(logic [31:0] v, logic sgn);
		return (sgn && v[31]) ? 32'h0 - v : v;
	endfunction : mag

	// Full product of two words, signed or unsigned.
	function automatic logic [63:0] mul64(logic [31:0] x, logic [31:0] y,
		logic sgn);
		logic [63:0] ex;
		logic [63:0] ey;
		ex = {{32{sgn & x[31]}}, x};
		ey = {{32{sgn & y[31]}}, y};
		return ex * ey;
	endfunction : mul64

	// ****************************************
	// State.
	// ****************************************
	exu_pkg::exu_state_t st;
	exu_pkg::exu_state_t nx;
	exu_pkg::exu_op_t    op;
	logic [31:0] rd;
	logic [31:0] wd;
	logic [31:0] addr;
	logic [31:0] sh;
	logic [31:0] cp0;
	logic [31:0] br_tgt;
	logic [63:0] prod;
	logic [63:0] hilo;
	logic [32:0] part_rem;
	logic [31:0] hi_n;
	logic [31:0] lo_n;
	logic        ge;
	logic        is_br;
	logic        cond;
	logic        likely;
	logic        wr_go;

	assign avs_readdata    = st.rdata;
	assign avs_waitrequest = st.wait_r;

	// ****************************************
	// Next-state logic.
	// ****************************************
	always_comb begin
		nx = st;
		rd = 32'h0;
		wd = avs_writedata;
		op = exu_pkg::exu_op_t'(wd[5:0]);
		addr = st.a + sext16(st.imm);
		sh = st.mem_data >> {addr[1:0], 3'b000};
		br_tgt = st.pc + (sext16(st.imm) << 2);
		hilo = {st.hi, st.lo};
		prod = 64'h0;
		part_rem = {st.hi, st.lo[31]};
		ge = part_rem >= {1'b0, st.den};
		hi_n = ge ? 32'(part_rem - {1'b0, st.den}) : part_rem[31:0];
		lo_n = {st.lo[30:0], ge};
		is_br = 1'b0;
		cond = 1'b0;
		likely = 1'b0;
		wr_go = avs_write && !st.wait_r;
		case (st.imm[15:11])
			exu_pkg::EXU_CP0_SW:   cp0 = st.sw;
			exu_pkg::EXU_CP0_XPC:  cp0 = st.xpc;
			exu_pkg::EXU_CP0_EEPC: cp0 = st.eepc;
			exu_pkg::EXU_CP0_DPC:  cp0 = st.dpc;
			exu_pkg::EXU_CP0_LINK: cp0 = st.link_addr;
			default:               cp0 = 32'h0;
		endcase
		if (st.imm[2:0] != 3'h0) begin
			cp0 = 32'h0;
		end

		// Register read multiplexer.
		case (avs_address)
			exu_pkg::EXU_OFS_SRC_A:    rd = st.a;
			exu_pkg::EXU_OFS_SRC_B:    rd = st.b;
			exu_pkg::EXU_OFS_PC:       rd = st.pc;
			exu_pkg::EXU_OFS_IMM:      rd = st.imm;
			exu_pkg::EXU_OFS_MEM_DATA: rd = st.mem_data;
			exu_pkg::EXU_OFS_RESULT:   rd = st.result;
			exu_pkg::EXU_OFS_STATUS: begin
				rd[exu_pkg::EXU_ST_BUSY]  = st.fsm == exu_pkg::EXU_DIVIDE;
				rd[exu_pkg::EXU_ST_WR]    = st.dest_wr;
				rd[exu_pkg::EXU_ST_TAKEN] = st.taken;
				rd[exu_pkg::EXU_ST_NULL]  = st.nullify;
				rd[exu_pkg::EXU_ST_BRK]   = st.brk;
				rd[exu_pkg::EXU_ST_DBG]   = st.dbg;
				rd[exu_pkg::EXU_ST_LINK]  = st.llflag;
				rd[12:8] = st.dest;
			end
			exu_pkg::EXU_OFS_NEXT_PC:  rd = st.next_pc;
			exu_pkg::EXU_OFS_HI:       rd = st.hi;
			exu_pkg::EXU_OFS_LO:       rd = st.lo;
			exu_pkg::EXU_OFS_EXC_PC:   rd = st.xpc;
			exu_pkg::EXU_OFS_ERR_PC:   rd = st.eepc;
			exu_pkg::EXU_OFS_DBG_PC:   rd = st.dpc;
			exu_pkg::EXU_OFS_SW:       rd = st.sw;
			exu_pkg::EXU_OFS_LINK:     rd = st.link_addr;
			exu_pkg::EXU_OFS_MEM_ADDR: rd = st.mem_addr;
			default:                   rd = 32'h0;
		endcase

		// Bus handshake: one wait cycle, writes held off while dividing.
		nx.wait_r = 1'b1;
		if ((avs_read || avs_write) && st.wait_r &&
			!(avs_write && st.fsm == exu_pkg::EXU_DIVIDE)) begin
			nx.wait_r = 1'b0;
			nx.rdata = rd;
		end

		// Iterative restoring divider, one quotient bit per cycle.
		case (st.fsm)
			exu_pkg::EXU_IDLE: begin
			end
			exu_pkg::EXU_DIVIDE: begin
				nx.hi = hi_n;
				nx.lo = lo_n;
				nx.div_cnt = st.div_cnt - 6'h01;
				if (st.div_cnt == 6'h01) begin
					nx.fsm = exu_pkg::EXU_IDLE;
					nx.hi = st.neg_r ? 32'h0 - hi_n : hi_n;
					nx.lo = st.neg_q ? 32'h0 - lo_n : lo_n;
				end
			end
			default: nx.fsm = exu_pkg::EXU_IDLE;
		endcase

		// Register writes, taken at the edge that ends the answer cycle, while waitrequest is low.
		if (wr_go) begin
			case (avs_address)
				exu_pkg::EXU_OFS_SRC_A:    nx.a = merge(st.a, wd, avs_byteenable);
				exu_pkg::EXU_OFS_SRC_B:    nx.b = merge(st.b, wd, avs_byteenable);
				exu_pkg::EXU_OFS_PC:       nx.pc = merge(st.pc, wd, avs_byteenable);
				exu_pkg::EXU_OFS_IMM:      nx.imm = merge(st.imm, wd, avs_byteenable);
				exu_pkg::EXU_OFS_MEM_DATA:
					nx.mem_data = merge(st.mem_data, wd, avs_byteenable);
				exu_pkg::EXU_OFS_STATUS:
					if (avs_byteenable[0]) begin
						nx.dbg = wd[exu_pkg::EXU_ST_DBG];
					end
				exu_pkg::EXU_OFS_HI:     nx.hi = merge(st.hi, wd, avs_byteenable);
				exu_pkg::EXU_OFS_LO:     nx.lo = merge(st.lo, wd, avs_byteenable);
				exu_pkg::EXU_OFS_EXC_PC: nx.xpc = merge(st.xpc, wd, avs_byteenable);
				exu_pkg::EXU_OFS_ERR_PC: nx.eepc = merge(st.eepc, wd, avs_byteenable);
				exu_pkg::EXU_OFS_DBG_PC: nx.dpc = merge(st.dpc, wd, avs_byteenable);
				exu_pkg::EXU_OFS_SW:     nx.sw = merge(st.sw, wd, avs_byteenable);
				exu_pkg::EXU_OFS_CMD: begin
					nx.dest = wd[12:8];
					nx.dest_wr = 1'b0;
					nx.taken = 1'b0;
					nx.nullify = 1'b0;
					nx.brk = 1'b0;
					nx.result = 32'h0;
					nx.next_pc = st.pc + 32'h4;
					case (op)
						exu_pkg::OP_BLE_Z, exu_pkg::OP_BLE_ZL: begin
							is_br = 1'b1;
							cond = st.a[31] || st.a == 32'h0;
							likely = op == exu_pkg::OP_BLE_ZL;
						end
						exu_pkg::OP_BNEG, exu_pkg::OP_BNEG_L: begin
							is_br = 1'b1;
							cond = st.a[31];
							likely = op == exu_pkg::OP_BNEG_L;
						end
						exu_pkg::OP_BNEG_LNK, exu_pkg::OP_BNEG_LNKL: begin
							is_br = 1'b1;
							cond = st.a[31];
							likely = op == exu_pkg::OP_BNEG_LNKL;
							nx.dest = exu_pkg::EXU_LINK_REG;
							nx.result = st.pc + 32'h8;
							nx.dest_wr = 1'b1;
						end
						exu_pkg::OP_BUNEQ, exu_pkg::OP_BUNEQ_L: begin
							is_br = 1'b1;
							cond = st.a != st.b;
							likely = op == exu_pkg::OP_BUNEQ_L;
						end
						exu_pkg::OP_BREAKPT: nx.brk = 1'b1;
						exu_pkg::OP_CNT_ONES, exu_pkg::OP_CNT_ZEROS: begin
							nx.result = {26'h0, lead_count(st.a,
								op == exu_pkg::OP_CNT_ONES)};
							nx.dest_wr = 1'b1;
						end
						exu_pkg::OP_DBG_RET: begin
							nx.next_pc = st.dpc;
							nx.dbg = 1'b0;
						end
						exu_pkg::OP_DIV_S, exu_pkg::OP_DIV_U: begin
							cond = op == exu_pkg::OP_DIV_S;
							nx.fsm = exu_pkg::EXU_DIVIDE;
							nx.div_cnt = exu_pkg::EXU_DIV_STEPS;
							nx.hi = 32'h0;
							nx.lo = mag(st.a, cond);
							nx.den = mag(st.b, cond);
							nx.neg_q = cond & (st.a[31] ^ st.b[31]);
							nx.neg_r = cond & st.a[31];
						end
						exu_pkg::OP_EXC_RET: begin
							nx.next_pc = st.sw[exu_pkg::EXU_SW_ERL] ?
								st.eepc : st.xpc;
							nx.sw[exu_pkg::EXU_SW_EXL] = 1'b0;
							nx.sw[exu_pkg::EXU_SW_ERL] = 1'b0;
							nx.llflag = 1'b0;
						end
						exu_pkg::OP_JMP, exu_pkg::OP_JMP_LNK: begin
							nx.next_pc = {st.pc[31:28], st.imm[25:0], 2'b00};
							nx.taken = 1'b1;
							if (op == exu_pkg::OP_JMP_LNK) begin
								nx.dest = exu_pkg::EXU_LINK_REG;
								nx.result = st.pc + 32'h8;
								nx.dest_wr = 1'b1;
							end
						end
						exu_pkg::OP_RJMP, exu_pkg::OP_RJMP_LNK: begin
							nx.next_pc = st.a;
							nx.taken = 1'b1;
							nx.result = st.pc + 32'h8;
							nx.dest_wr = op == exu_pkg::OP_RJMP_LNK;
						end
						exu_pkg::OP_LD_BS, exu_pkg::OP_LD_BZ: begin
							nx.mem_addr = addr;
							nx.result = {{24{sh[7] & (op == exu_pkg::OP_LD_BS)}},
								sh[7:0]};
							nx.dest_wr = 1'b1;
						end
						exu_pkg::OP_LD_HS, exu_pkg::OP_LD_HZ: begin
							nx.mem_addr = addr;
							nx.result = {{16{sh[15] & (op == exu_pkg::OP_LD_HS)}},
								sh[15:0]};
							nx.dest_wr = 1'b1;
						end
						exu_pkg::OP_LD_WORD, exu_pkg::OP_LD_LNK: begin
							nx.mem_addr = addr;
							nx.result = st.mem_data;
							nx.dest_wr = 1'b1;
							if (op == exu_pkg::OP_LD_LNK) begin
								nx.llflag = 1'b1;
								nx.link_addr = addr;
							end
						end
						exu_pkg::OP_LD_UPPER: begin
							nx.result = {st.imm[15:0], 16'h0};
							nx.dest_wr = 1'b1;
						end
						exu_pkg::OP_MACC, exu_pkg::OP_MACC_U,
						exu_pkg::OP_MUL_SUBTRACT_S, exu_pkg::OP_MUL_SUBTRACT_U: begin
							prod = mul64(st.a, st.b, op == exu_pkg::OP_MACC ||
								op == exu_pkg::OP_MUL_SUBTRACT_S);
							hilo = (op == exu_pkg::OP_MACC ||
								op == exu_pkg::OP_MACC_U) ?
								hilo + prod : hilo - prod;
							{nx.hi, nx.lo} = hilo;
						end
						exu_pkg::OP_MUL_S, exu_pkg::OP_MUL_U: begin
							{nx.hi, nx.lo} = mul64(st.a, st.b,
								op == exu_pkg::OP_MUL_S);
						end
						exu_pkg::OP_MUL_REG: begin
							prod = mul64(st.a, st.b, 1'b1);
							nx.result = prod[31:0];
							nx.dest_wr = 1'b1;
						end
						exu_pkg::OP_RD_HI, exu_pkg::OP_RD_LO: begin
							nx.result = op == exu_pkg::OP_RD_HI ?
								st.hi : st.lo;
							nx.dest_wr = 1'b1;
						end
						exu_pkg::OP_WR_HI: nx.hi = st.a;
						exu_pkg::OP_WR_LO: nx.lo = st.a;
						exu_pkg::OP_MOV_NZ, exu_pkg::OP_MOV_Z: begin
							nx.result = st.a;
							nx.dest_wr = (st.b != 32'h0) ==
								(op == exu_pkg::OP_MOV_NZ);
						end
						exu_pkg::OP_CP_RD: begin
							nx.result = cp0;
							nx.dest_wr = 1'b1;
						end
						exu_pkg::OP_CP_WR: begin
							if (st.imm[2:0] == 3'h0) begin
								case (st.imm[15:11])
									exu_pkg::EXU_CP0_SW:   nx.sw = st.b;
									exu_pkg::EXU_CP0_XPC:  nx.xpc = st.b;
									exu_pkg::EXU_CP0_EEPC: nx.eepc = st.b;
									exu_pkg::EXU_CP0_DPC:  nx.dpc = st.b;
									exu_pkg::EXU_CP0_LINK: nx.link_addr = st.b;
									default: nx.link_addr = st.link_addr;
								endcase
							end
						end
						default: nx.brk = 1'b0;
					endcase
					if (is_br) begin
						nx.taken = cond;
						nx.next_pc = cond ? br_tgt : st.pc + 32'h4;
						nx.nullify = likely && !cond;
					end
				end
				default: nx.rdata = st.rdata;
			endcase
		end
	end

	// ****************************************
	// State register.
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st <= exu_pkg::EXU_STATE_RST;
		end else if (clk_en) begin
			st <= nx;
		end
	end

endmodule : exu_core

// ### testbench/exu_core_monitor.sv
// Bus timing checker for the execution block.
`timescale 1ns/1ps
module exu_monitor (
	// Clock, reset and enable.
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        clk_en,
	// Avalon-MM slave port.
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest
);
	// ****************************************
	// Sequences and assertions.
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_div_cmd;
		avs_write && avs_waitrequest && clk_en && avs_address == 8'h00 &&
		(avs_writedata[5:0] == exu_pkg::OP_DIV_S ||
		avs_writedata[5:0] == exu_pkg::OP_DIV_U);
	endsequence
	sequence s_ack;
		!avs_waitrequest;
	endsequence
	a_wait_reset: assert property (@(posedge ref_clk) disable iff (1'b0)
		reset |=> avs_waitrequest && avs_readdata == 32'h0)
		else $error("bus not idle after reset");
	a_ack_single: assert property (!avs_waitrequest && clk_en |=>
		avs_waitrequest) else $error("answer longer than one cycle");
	a_read_latency: assert property (avs_read && avs_waitrequest && clk_en
		|=> s_ack) else $error("read not answered next cycle");
	a_no_spurious: assert property (!avs_waitrequest |->
		$past(avs_read || avs_write)) else $error("answer without request");
	a_unmapped_zero: assert property (avs_read && avs_waitrequest && clk_en
		&& avs_address == 8'h44 |=> s_ack and avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_data_stands: assert property (!$stable(avs_readdata) |->
		!avs_waitrequest) else $error("read data moved outside answer");
	a_freeze_state: assert property (!clk_en |=> $stable(avs_waitrequest)
		&& $stable(avs_readdata)) else $error("state moved while frozen");
	a_div_stall: assert property (s_div_cmd ##1 s_ack ##2
		(avs_write && clk_en) |-> avs_waitrequest [*8])
		else $error("write not held during divide");
	a_ack_bound: assert property (@(posedge ref_clk) disable iff (reset ||
		!clk_en) (avs_read || avs_write) && avs_waitrequest |->
		##[0:40] s_ack) else $error("request never answered");
	c_div: cover property (s_div_cmd ##1 s_ack);
endmodule : exu_monitor

bind exu_core exu_monitor u_exu_monitor (.ref_clk(ref_clk), .reset(reset),
	.clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_byteenable(avs_byteenable),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest));

// ### testbench/exu_host_model.sv
// Avalon-MM master standing in for the decode side.
`timescale 1ns/1ps
module exu_host_model (
	// Clock.
	input  wire logic        ref_clk,
	// Answer.
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	// Request.
	output logic      [7:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [3:0]  avs_byteenable,
	output logic      [31:0] avs_writedata
);
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'hF;
		avs_writedata = 32'h0;
	end
	// Holds the request until waitrequest is seen low, then releases.
	task automatic bus(input logic wr, input logic [7:0] ad,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= ad;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d;
	endtask : bus
endmodule : exu_host_model

// ### testbench/exu_core_test.sv
// Self-checking bench of the execution block.
`timescale 1ns/1ps
module exu_core_test;
	logic        ref_clk, reset, clk_en, avs_read, avs_write, avs_waitrequest;
	logic [7:0]  avs_address, what;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, a, b, pc, imm, md, q, e, r, t, v;
	logic [63:0] hl, ps, pu;
	logic [4:0]  dest;
	logic        tk, lk, ly, w;
	int          errors, checks_done;
	int          ml[11] = '{36, 37, 26, 27, 33, 34, 39, 40, 38, 29, 30};
	int          jl[4] = '{15, 16, 18, 17};

	exu_core u_exu_core (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	exu_host_model u_exu_host_model (.ref_clk(ref_clk),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata));

	// ****************************************
	// Tasks.
	// ****************************************
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch reg %h expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic rw(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		u_exu_host_model.bus(wr, ad, d, q);
		what = ad;
	endtask : rw
	task automatic rdm(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] x);
		rw(1'b0, ad, 32'h0);
		chk(q & m, x);
	endtask : rdm
	task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
		rdm(ad, 32'hFFFFFFFF, x);
	endtask : rdc
	task automatic ex(input int op);
		rw(1'b1, 8'h04, a);
		rw(1'b1, 8'h08, b);
		rw(1'b1, 8'h0C, pc);
		rw(1'b1, 8'h10, imm);
		rw(1'b1, 8'h14, md);
		rw(1'b1, 8'h00, {19'h0, dest, 2'h0, op[5:0]});
	endtask : ex
	function automatic logic [31:0] lead(input logic [31:0] x, input logic bv);
		lead = 0;
		while (lead < 32 && x[31 - lead] == bv) lead++;
	endfunction : lead

	// ****************************************
	// Clock, reset, watchdog and tests.
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		errors++;
		give_verdict();
	end
	initial begin
		reset = 1'b1;
		clk_en = 1'b1;
		errors = 0;
		checks_done = 0;
		hl = 64'h0;
		md = 32'h0;
		dest = 5'h03;
		void'($urandom(81476));
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		for (int i = 4; i < 72; i += 4) rdc(i[7:0], 32'h0);
		for (int j = 0; j < 24; j++) begin
			a = j % 3 == 0 ? 0 : j % 3 == 1 ? $urandom() | 32'h80000000 :
				$urandom() & 32'h7FFFFFFE | 1;
			b = j % 3 == 2 ? a : a ^ 32'h1;
			pc = $urandom() & 32'hFFFFFFFC;
			imm = $urandom() & 32'hFFFF;
			tk = j < 6 ? a[31] || a == 0 : j < 18 ? a[31] : a != b;
			lk = j / 3 == 4 || j / 3 == 5;
			ly = j / 3 % 2 == 1;
			ex(j / 3);
			t = pc + {{14{imm[15]}}, imm[15:0], 2'b00};
			rdc(8'h20, tk ? t : pc + 4);
			rdm(8'h1C, 32'hE, {28'h0, ly && !tk, tk, lk, 1'b0});
			if (lk) rdc(8'h18, pc + 8);
		end
		for (int k = 0; k < 4; k++) begin
			a = $urandom() & 32'hFFFFFFFC;
			pc = $urandom() & 32'hFFFFFFFC;
			imm = $urandom();
			dest = 5'h07;
			ex(jl[k]);
			rdc(8'h20, k < 2 ? {pc[31:28], imm[25:0], 2'b00} : a);
			if (k % 2 == 1) rdc(8'h18, pc + 8);
			if (k % 2 == 1) rdm(8'h1C, 32'h1F02, k == 1 ? 32'h1F02 : 32'h0702);
		end
		for (int i = 19; i < 26; i++) begin
			a = $urandom();
			imm = $urandom() & 32'hFFFF;
			md = $urandom();
			ex(i);
			t = a + {{16{imm[15]}}, imm[15:0]};
			v = md >> {t[1:0], 3'b000};
			case (i)
				19: e = {{24{v[7]}}, v[7:0]};
				20: e = {24'h0, v[7:0]};
				21: e = {{16{v[15]}}, v[15:0]};
				22: e = {16'h0, v[15:0]};
				24: e = {imm[15:0], 16'h0};
				default: e = md;
			endcase
			rdc(8'h18, e);
			if (i == 23) rdc(8'h3C, t);
			if (i == 23) rdm(8'h1C, 32'h40, 32'h40);
		end
		rw(1'b1, 8'h18, ~e);
		rdc(8'h18, e);
		rdc(8'h44, 32'h0);
		for (int k = 0; k < 22; k++) begin
			a = $urandom();
			b = $urandom();
			ps = longint'($signed(a)) * longint'($signed(b));
			pu = {32'h0, a} * {32'h0, b};
			ex(ml[k % 11]);
			case (ml[k % 11])
				36: hl[63:32] = a;
				37: hl[31:0] = a;
				26: hl = hl + ps;
				27: hl = hl + pu;
				33: hl = hl - ps;
				34: hl = hl - pu;
				39: hl = ps;
				40: hl = pu;
				38: e = ps[31:0];
				29: e = hl[63:32];
				default: e = hl[31:0];
			endcase
			rdc(8'h24, hl[63:32]);
			rdc(8'h28, hl[31:0]);
			if (k % 11 > 7) rdc(8'h18, e);
		end
		for (int i = 12; i < 14; i++) begin
			a = $urandom();
			b = $urandom() | 1;
			if (i == 12) begin
				e = $signed(a) / $signed(b);
				r = $signed(a) % $signed(b);
			end else begin
				e = a / b;
				r = a % b;
			end
			ex(i);
			rw(1'b1, 8'h04, a);
			rdc(8'h28, e);
			rdc(8'h24, r);
		end
		for (int k = 0; k < 4; k++) begin
			a = $urandom();
			b = k < 2 ? 0 : $urandom() | 1;
			w = (k % 2 == 0) == (b != 0);
			ex(31 + k % 2);
			rdm(8'h1C, 32'h2, {30'h0, w, 1'b0});
			if (w) rdc(8'h18, a);
		end
		for (int k = 0; k < 6; k++) begin
			a = k < 2 ? 0 : k < 4 ? 32'hFFFFFFFF : $urandom();
			ex(9 + k % 2);
			rdc(8'h18, lead(a, k % 2 == 0));
		end
		b = $urandom();
		imm = 32'h1000;
		ex(35);
		rdc(8'h2C, b);
		ex(28);
		rdc(8'h18, b);
		for (int k = 0; k < 2; k++) begin
			v = $urandom() & 32'hFFFFFFFB | k << 2;
			rw(1'b1, 8'h38, v);
			rw(1'b1, 8'h2C, a);
			rw(1'b1, 8'h30, b);
			ex(23);
			ex(14);
			rdc(8'h20, k == 1 ? b : a);
			rdc(8'h38, v & 32'hFFFFFFF9);
			rdm(8'h1C, 32'h40, 32'h0);
		end
		rw(1'b1, 8'h1C, 32'h20);
		rdm(8'h1C, 32'h20, 32'h20);
		rw(1'b1, 8'h34, a);
		ex(11);
		rdc(8'h20, a);
		rdm(8'h1C, 32'h20, 32'h0);
		ex(8);
		rdm(8'h1C, 32'h10, 32'h10);
		clk_en <= 1'b0;
		repeat (3) @(posedge ref_clk);
		clk_en <= 1'b1;
		rdm(8'h1C, 32'h10, 32'h10);
		give_verdict();
	end
endmodule : exu_core_test
